// ---- design/cfgmsg_pkg.sv ----
// Constants and types for the configuration message access block
package cfgmsg_pkg;
  localparam int TOKW = 8;
  localparam int RETW = 24;
  localparam int WORDW = 32;
  localparam int ENTRY_W = 1 + TOKW + RETW;
  localparam logic [7:0] TOK_WR_CFG = 8'hc0;
  localparam logic [7:0] TOK_RD_CFG = 8'hc1;
  localparam logic [7:0] TOK_WR_PER = 8'h24;
  localparam logic [7:0] TOK_RD_PER = 8'h25;
  localparam logic [7:0] TOK_ACK = 8'h03;
  localparam logic [7:0] TOK_NAK = 8'h04;
  localparam logic [7:0] TOK_END = 8'h01;
  localparam logic [15:0] DST_TILE = 16'hc20c;
  localparam logic [15:0] DST_NODE = 16'hc30c;
  localparam logic [7:0] DST_PER = 8'h02;
  localparam logic [7:0] PS_RES_TYPE = 8'h0b;
  localparam int PS_NUM_POS = 8;
  localparam logic [7:0] NO_REPLY = 8'hff;
  localparam logic [7:0] RET_BYTES = 8'h03;
  localparam logic [7:0] CFG_REG_BYTES = 8'h02;
  localparam logic [7:0] PER_REG_BYTES = 8'h01;
  localparam logic [7:0] CFG_DATA_BYTES = 8'h04;
  localparam int PER_MAX_SIZE = 4;
  localparam logic [31:0] REG_RESET = 32'h00000000;
  // Identity values are arbitrary
  localparam logic [15:0] TILE_ID_DEF = 16'h0001;
  localparam logic [15:0] NODE_ID_DEF = 16'h0002;
  typedef enum logic [6:0] {
    S_IDLE = 7'h01, S_RET = 7'h02, S_REG = 7'h04, S_SIZE = 7'h08,
    S_DATA = 7'h10, S_END = 7'h20, S_REPLY = 7'h40
  } state_t;
  typedef enum logic [1:0] {T_TILE = 2'h0, T_NODE = 2'h1, T_PER = 2'h2, T_NONE = 2'h3} tgt_t;
endpackage

// ---- design/tok_if.sv ----
// Token stream carrier between the interpreter and the reply buffer
`timescale 1ns/1ps
interface tok_if;
  logic valid;
  logic ready;
  logic ctrl;
  logic [7:0] data;
  logic [23:0] ret;
  modport src (output valid, output ctrl, output data, output ret, input ready);
  modport snk (input valid, input ctrl, input data, input ret, output ready);
endinterface // tok_if

// ---- design/tok_buf.sv ----
// Small FIFO holding reply tokens until the receiver takes them
`timescale 1ns/1ps
module tok_buf #(
  parameter int W = 33,
  parameter int DEPTH = 2
) (
  input wire logic clk,
  input wire logic rst_n,
  tok_if.snk push,
  output logic o_valid,
  input wire logic o_ready,
  output logic o_ctrl,
  output logic [7:0] o_data,
  output logic [23:0] o_ret
);
  // DEPTH must be a power of two, 2 or more, so the pointers wrap by themselves
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [AW:0] cnt;
  wire full = (cnt == (AW+1)'(DEPTH));
  wire empty = (cnt == '0);
  wire do_push = push.valid && !full;
  wire do_pop = o_valid && o_ready;
  assign push.ready = !full;
  assign o_valid = !empty;
  assign o_ctrl = mem[rp][W-1];
  assign o_data = mem[rp][W-2 -: 8];
  assign o_ret = mem[rp][23:0];
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
      for (int i = 0; i < DEPTH; i++) mem[i] <= '0;
    end else begin
      if (do_push) begin
        mem[wp] <= {push.ctrl, push.data, push.ret};
        wp <= wp + 1'b1;
      end
      if (do_pop) rp <= rp + 1'b1;
      cnt <= cnt + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end
endmodule // tok_buf

// ---- design/cfg_msg_access.sv ----
// Interpreter for configuration register access messages
`timescale 1ns/1ps
module cfg_msg_access #(
  parameter logic [15:0] TILE_ID = cfgmsg_pkg::TILE_ID_DEF,
  parameter logic [15:0] NODE_ID = cfgmsg_pkg::NODE_ID_DEF,
  parameter int NUM_TILE_REGS = 8,
  parameter int NUM_NODE_REGS = 8,
  parameter int NUM_PER = 4,
  parameter int PER_REGS = 16,
  parameter int NUM_PS = 16,
  parameter int BUF_DEPTH = 2
) (
  input wire logic MCLK,
  input wire logic NRST,
  input wire logic IN_VALID,
  output logic IN_READY,
  input wire logic IN_CTRL,
  input wire logic [cfgmsg_pkg::TOKW-1:0] IN_DATA,
  input wire logic [cfgmsg_pkg::WORDW-1:0] IN_DEST,
  output logic OUT_VALID,
  input wire logic OUT_READY,
  output logic OUT_CTRL,
  output logic [cfgmsg_pkg::TOKW-1:0] OUT_DATA,
  output logic [cfgmsg_pkg::RETW-1:0] OUT_RET,
  input wire logic PS_REQ,
  input wire logic PS_WE,
  input wire logic [15:0] PS_RID,
  input wire logic [cfgmsg_pkg::WORDW-1:0] PS_WDATA,
  output logic [cfgmsg_pkg::WORDW-1:0] PS_RDATA,
  output logic PS_DONE,
  output logic PS_ERR,
  output logic BUSY
);
  import cfgmsg_pkg::*;
  localparam int TIW = (NUM_TILE_REGS > 1) ? $clog2(NUM_TILE_REGS) : 1;
  localparam int NIW = (NUM_NODE_REGS > 1) ? $clog2(NUM_NODE_REGS) : 1;
  localparam int PSW = (NUM_PS > 1) ? $clog2(NUM_PS) : 1;
  localparam int PER_TOTAL = NUM_PER * PER_REGS;

  state_t st;
  tgt_t tgt;
  logic is_wr;
  logic fail;
  logic ok;
  logic [23:0] ret;
  logic [15:0] regn;
  logic [7:0] size;
  logic [7:0] perid;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic [7:0] cnt;
  logic [2:0] nbytes;
  logic [2:0] rcnt;
  logic [31:0] per_word;
  logic [31:0] tile_regs [NUM_TILE_REGS];
  logic [31:0] node_regs [NUM_NODE_REGS];
  logic [7:0] per_regs [PER_TOTAL];
  logic [31:0] ps_regs [NUM_PS];
  tok_if bi ();

  ////////////////////////////////////////////////////////////////////////////////
  // Decode
  wire fire = IN_VALID && IN_READY;
  wire tok_end = IN_CTRL && (IN_DATA == TOK_END);
  wire hit_tile = (IN_DEST[15:0] == DST_TILE) && (IN_DEST[31:16] == TILE_ID);
  wire hit_node = (IN_DEST[15:0] == DST_NODE) && (IN_DEST[31:16] == NODE_ID);
  wire hit_per = (IN_DEST[7:0] == DST_PER) && (IN_DEST[31:16] == NODE_ID)
                 && (int'(IN_DEST[15:8]) < NUM_PER);
  wire tgt_t next_tgt = hit_tile ? T_TILE : hit_node ? T_NODE : hit_per ? T_PER : T_NONE;
  wire hdr_wr = (IN_DATA == TOK_WR_CFG) || (IN_DATA == TOK_WR_PER);
  wire cfg_hdr = (IN_DATA == TOK_WR_CFG) || (IN_DATA == TOK_RD_CFG);
  wire per_hdr = (IN_DATA == TOK_WR_PER) || (IN_DATA == TOK_RD_PER);
  wire hdr_ok = ((next_tgt == T_TILE || next_tgt == T_NODE) && cfg_hdr)
                || (next_tgt == T_PER && per_hdr);
  wire [7:0] reg_len = (tgt == T_PER) ? PER_REG_BYTES : CFG_REG_BYTES;
  wire [7:0] data_len = (tgt == T_PER) ? size : CFG_DATA_BYTES;
  wire [2:0] rd_len = (tgt == T_PER) ? size[2:0] : CFG_DATA_BYTES[2:0];
  wire integer per_base = int'(perid) * PER_REGS + int'(regn[7:0]);
  wire range_ok = (tgt == T_TILE) ? (int'(regn) < NUM_TILE_REGS)
                : (tgt == T_NODE) ? (int'(regn) < NUM_NODE_REGS)
                : (tgt == T_PER) ? (size != 8'h00 && int'(size) <= PER_MAX_SIZE
                                    && int'(regn[7:0]) + int'(size) <= PER_REGS)
                : 1'b0;
  wire in_msg = (st != S_IDLE) && (st != S_REPLY);
  wire done = fire && tok_end && in_msg;
  wire msg_ok = (st == S_END) && !fail && range_ok;
  wire suppress = is_wr && (ret[7:0] == NO_REPLY);
  wire commit = done && msg_ok && is_wr;
  wire tile_we = commit && (tgt == T_TILE);
  wire node_we = commit && (tgt == T_NODE);
  wire per_we = commit && (tgt == T_PER);
  wire [31:0] rd_word = (tgt == T_TILE) ? tile_regs[regn[TIW-1:0]]
                      : (tgt == T_NODE) ? node_regs[regn[NIW-1:0]] : per_word;
  wire ps_hit = (PS_RID[7:0] == PS_RES_TYPE) && (int'(PS_RID[15:PS_NUM_POS]) < NUM_PS);
  wire [PSW-1:0] ps_idx = PS_RID[PS_NUM_POS +: PSW];

  assign IN_READY = (st != S_REPLY);
  assign BUSY = (st != S_IDLE);
  assign bi.valid = (st == S_REPLY);
  assign bi.ctrl = (rcnt == 3'h0) || (rcnt > nbytes);
  assign bi.data = (rcnt == 3'h0) ? (ok ? TOK_ACK : TOK_NAK)
                 : (rcnt > nbytes) ? TOK_END : rdat[31:24];
  assign bi.ret = ret;

  // Peripheral bytes packed first byte highest, so replies go out MSB first
  always_comb begin
    per_word = '0;
    for (int k = 0; k < PER_MAX_SIZE; k++) begin
      if (k < int'(size)) per_word[WORDW-1-8*k -: 8] = per_regs[(per_base + k) % PER_TOTAL];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Message parser and reply sequencer
  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      st <= S_IDLE;
      tgt <= T_NONE;
      is_wr <= 1'b0;
      fail <= 1'b0;
      ok <= 1'b0;
      ret <= '0;
      regn <= '0;
      size <= '0;
      perid <= '0;
      wdat <= '0;
      rdat <= '0;
      cnt <= '0;
      nbytes <= '0;
      rcnt <= '0;
    end else if (done) begin
      ok <= msg_ok;
      nbytes <= (msg_ok && !is_wr) ? rd_len : 3'h0;
      rdat <= rd_word;
      rcnt <= '0;
      st <= suppress ? S_IDLE : S_REPLY;
    end else if (fire && IN_CTRL && in_msg) begin
      // Any other control token mid-message spoils it; wait for the end
      fail <= 1'b1;
      st <= S_END;
    end else begin
      case (st)
        S_IDLE: begin
          // Stray data tokens between messages are dropped
          if (fire && IN_CTRL) begin
            tgt <= next_tgt;
            is_wr <= hdr_wr;
            fail <= !hdr_ok;
            perid <= IN_DEST[15:8];
            regn <= '0;
            size <= '0;
            cnt <= '0;
            st <= S_RET;
          end
        end
        S_RET: begin
          if (fire) begin
            ret <= {ret[15:0], IN_DATA};
            cnt <= (cnt == RET_BYTES - 8'h01) ? 8'h00 : cnt + 8'h01;
            if (cnt == RET_BYTES - 8'h01) st <= S_REG;
          end
        end
        S_REG: begin
          if (fire) begin
            regn <= {regn[7:0], IN_DATA};
            cnt <= (cnt == reg_len - 8'h01) ? 8'h00 : cnt + 8'h01;
            if (cnt == reg_len - 8'h01) st <= (tgt == T_PER) ? S_SIZE : is_wr ? S_DATA : S_END;
          end
        end
        S_SIZE: begin
          if (fire) begin
            size <= IN_DATA;
            st <= (is_wr && IN_DATA != 8'h00) ? S_DATA : S_END;
          end
        end
        S_DATA: begin
          if (fire) begin
            wdat <= {wdat[23:0], IN_DATA};
            cnt <= (cnt == data_len - 8'h01) ? 8'h00 : cnt + 8'h01;
            if (cnt == data_len - 8'h01) st <= S_END;
          end
        end
        S_END: begin
          if (fire) fail <= 1'b1;
        end
        S_REPLY: begin
          if (bi.ready) begin
            if (rcnt > nbytes) begin
              st <= S_IDLE;
              rcnt <= '0;
            end else begin
              rcnt <= rcnt + 3'h1;
              if (rcnt != 3'h0) rdat <= {rdat[23:0], 8'h00};
            end
          end
        end
        default: st <= S_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register banks, written only on a complete, valid write message
  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      for (int i = 0; i < NUM_TILE_REGS; i++) tile_regs[i] <= REG_RESET;
      for (int i = 0; i < NUM_NODE_REGS; i++) node_regs[i] <= REG_RESET;
      for (int i = 0; i < PER_TOTAL; i++) per_regs[i] <= REG_RESET[7:0];
    end else begin
      if (tile_we) tile_regs[regn[TIW-1:0]] <= wdat;
      if (node_we) node_regs[regn[NIW-1:0]] <= wdat;
      for (int k = 0; k < PER_MAX_SIZE; k++) begin
        if (per_we && k < int'(size))
          per_regs[(per_base + k) % PER_TOTAL] <= wdat[8*(int'(size)-1-k) +: 8];
      end
    end
  end

  // Processor status access by resource identifier
  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      for (int i = 0; i < NUM_PS; i++) ps_regs[i] <= REG_RESET;
      PS_RDATA <= '0;
      PS_DONE <= 1'b0;
      PS_ERR <= 1'b0;
    end else begin
      PS_DONE <= PS_REQ;
      PS_ERR <= PS_REQ && !ps_hit;
      if (PS_REQ) PS_RDATA <= ps_hit ? ps_regs[ps_idx] : '0;
      if (PS_REQ && PS_WE && ps_hit) ps_regs[ps_idx] <= PS_WDATA;
    end
  end

  tok_buf #(.W(ENTRY_W), .DEPTH(BUF_DEPTH)) u_buf (
    .clk(MCLK),
    .rst_n(NRST),
    .push(bi),
    .o_valid(OUT_VALID),
    .o_ready(OUT_READY),
    .o_ctrl(OUT_CTRL),
    .o_data(OUT_DATA),
    .o_ret(OUT_RET)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!NRST);

  property p_no_reply;
    (done && is_wr && ret[7:0] == NO_REPLY) |=> st == S_IDLE && !bi.valid;
  endproperty
  a_no_reply: assert property (p_no_reply) else $error("reply sent for suppressed write");
  property p_ret_msb;
    (st == S_REG && $past(st) == S_RET) |-> ret[7:0] == $past(IN_DATA);
  endproperty
  a_ret_msb: assert property (p_ret_msb) else $error("return address byte order");
  property p_ps_bad;
    (PS_REQ && PS_RID[7:0] != 8'h0b) |=> PS_DONE && PS_ERR;
  endproperty
  a_ps_bad: assert property (p_ps_bad) else $error("bad status id not flagged");
  property p_tile_route;
    (st == S_IDLE && fire && IN_CTRL && IN_DEST[15:0] == 16'hc20c && IN_DEST[31:16] == TILE_ID)
      |=> tgt == T_TILE && st == S_RET;
  endproperty
  a_tile_route: assert property (p_tile_route) else $error("tile destination missed");
  property p_node_route;
    (st == S_IDLE && fire && IN_CTRL && IN_DEST[15:0] == 16'hc30c && IN_DEST[31:16] == NODE_ID)
      |=> tgt == T_NODE;
  endproperty
  a_node_route: assert property (p_node_route) else $error("node destination missed");
  property p_per_hdr;
    (st == S_IDLE && fire && IN_CTRL && IN_DATA == 8'h24 && hit_per) |=> is_wr && !fail;
  endproperty
  a_per_hdr: assert property (p_per_hdr) else $error("peripheral write header");
  property p_cfg_rd_hdr;
    (st == S_IDLE && fire && IN_CTRL && IN_DATA == 8'hc1 && hit_tile) |=> !is_wr && !fail;
  endproperty
  a_cfg_rd_hdr: assert property (p_cfg_rd_hdr) else $error("config read header");
  property p_wr_ack;
    (done && msg_ok && is_wr && ret[7:0] != 8'hff) |=> bi.valid && bi.ctrl && bi.data == 8'h03;
  endproperty
  a_wr_ack: assert property (p_wr_ack) else $error("write success reply");
  property p_nak;
    (done && !msg_ok && !suppress) |=> bi.valid && bi.ctrl && bi.data == 8'h04 && nbytes == 3'h0;
  endproperty
  a_nak: assert property (p_nak) else $error("failure reply");
  property p_rd_len;
    (done && msg_ok && !is_wr && tgt != T_PER) |=> nbytes == 3'h4;
  endproperty
  a_rd_len: assert property (p_rd_len) else $error("config read not 32 bits");
  property p_last_end;
    (bi.valid && bi.ready && rcnt > nbytes) |-> bi.ctrl && bi.data == 8'h01 ##1 st == S_IDLE;
  endproperty
  a_last_end: assert property (p_last_end) else $error("reply not closed");
  property p_commit_at_end;
    (tile_we || node_we || per_we) |-> st == S_END && fire && IN_CTRL && IN_DATA == 8'h01;
  endproperty
  a_commit_at_end: assert property (p_commit_at_end) else $error("early write");

  c_wr_ok: cover property (commit && !suppress);
  c_per_rd: cover property (done && msg_ok && !is_wr && tgt == T_PER);
  c_stall: cover property (bi.valid && !bi.ready);
  c_ps_wr: cover property (PS_REQ && PS_WE && ps_hit);
endmodule // cfg_msg_access

// ---- tb/cfg_requester.sv ----
// Requester model: sends token messages and collects the reply tokens
`timescale 1ns/1ps
module cfg_requester (
  input wire logic clk,
  output logic in_valid,
  input wire logic in_ready,
  output logic in_ctrl,
  output logic [7:0] in_data,
  output logic [31:0] in_dest,
  input wire logic out_valid,
  output logic out_ready,
  input wire logic out_ctrl,
  input wire logic [7:0] out_data,
  input wire logic [23:0] out_ret
);
  logic [8:0] rx[$];
  logic [23:0] rx_ret[$];
  logic stall = 1'b0;
  int seed = 48112;
  initial begin
    in_valid = 1'b0;
    in_ctrl = 1'b0;
    in_data = 8'h00;
    in_dest = 32'h00000000;
    out_ready = 1'b0;
  end
  // Token held until the edge that samples ready high
  task put(input logic [31:0] dst, input logic [8:0] t);
    @(negedge clk);
    in_valid = 1'b1;
    in_ctrl = t[8];
    in_data = t[7:0];
    in_dest = dst;
    while (!in_ready) @(negedge clk);
    @(posedge clk);
  endtask
  // Released data line flips so a stale byte never looks valid
  task release_bus();
    @(negedge clk);
    in_valid = 1'b0;
    in_data = ~in_data;
  endtask
  always @(negedge clk) begin
    out_ready = !stall && (($random(seed) & 3) != 0);
    if (out_valid && out_ready) begin
      rx.push_back({out_ctrl, out_data});
      rx_ret.push_back(out_ret);
    end
  end
endmodule // cfg_requester

// ---- tb/cfg_msg_access_tb.sv ----
// Self-checking bench for the configuration message interpreter
`timescale 1ns/1ps
module cfg_msg_access_tb;
  import cfgmsg_pkg::*;
  localparam logic [31:0] TD = {TILE_ID_DEF, DST_TILE};
  localparam logic [31:0] ND = {NODE_ID_DEF, DST_NODE};
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic in_valid, in_ready, in_ctrl, out_valid, out_ready, out_ctrl, ps_done, ps_err, busy;
  logic [7:0] in_data, out_data;
  logic [31:0] in_dest, ps_rdata;
  logic [23:0] out_ret;
  logic ps_req = 1'b0;
  logic ps_we = 1'b0;
  logic [15:0] ps_rid = 16'h0000;
  logic [31:0] ps_wdata = 32'h00000000;
  int fails = 0;
  int checks = 0;
  int seed = 48112;
  int r;
  logic [8:0] m[$], e[$];
  logic [31:0] tmod[8], nmod[8], psm[16];
  logic [7:0] pmod[4][16];
  logic [23:0] rt;
  cfg_msg_access #(.TILE_ID(TILE_ID_DEF), .NODE_ID(NODE_ID_DEF)) dut (.MCLK(mclk), .NRST(nrst),
    .IN_VALID(in_valid), .IN_READY(in_ready), .IN_CTRL(in_ctrl), .IN_DATA(in_data),
    .IN_DEST(in_dest), .OUT_VALID(out_valid), .OUT_READY(out_ready), .OUT_CTRL(out_ctrl),
    .OUT_DATA(out_data), .OUT_RET(out_ret), .PS_REQ(ps_req), .PS_WE(ps_we), .PS_RID(ps_rid),
    .PS_WDATA(ps_wdata), .PS_RDATA(ps_rdata), .PS_DONE(ps_done), .PS_ERR(ps_err), .BUSY(busy));
  cfg_requester req (.clk(mclk), .in_valid(in_valid), .in_ready(in_ready), .in_ctrl(in_ctrl),
    .in_data(in_data), .in_dest(in_dest), .out_valid(out_valid), .out_ready(out_ready),
    .out_ctrl(out_ctrl), .out_data(out_data), .out_ret(out_ret));
  initial forever #5 mclk = ~mclk;
  ////////////////////////////////////////////////////////////////////////////////
  function logic [8:0] ct(input logic [7:0] v);
    return {1'b1, v};
  endfunction
  function logic [8:0] dt(input logic [7:0] v);
    return {1'b0, v};
  endfunction
  function logic cfg_ok(input logic [31:0] dst, input logic [15:0] rn);
    return (dst == TD || dst == ND) && rn < 16'd8;
  endfunction
  task clear_models();
    foreach (tmod[i]) tmod[i] = REG_RESET;
    foreach (nmod[i]) nmod[i] = REG_RESET;
    foreach (psm[i]) psm[i] = REG_RESET;
    foreach (pmod[i, j]) pmod[i][j] = 8'h00;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task test_done();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task hdr(input logic [7:0] h, input logic [23:0] ret);
    m = {};
    m.push_back(ct(h));
    for (int i = 2; i >= 0; i--) m.push_back(dt(ret[8*i+:8]));
  endtask
  task fin(input logic ok);
    e = {};
    e.push_back(ct(ok ? TOK_ACK : TOK_NAK));
  endtask
  task run(input logic [31:0] dst, input logic [23:0] ret);
    int n;
    req.rx = {};
    req.rx_ret = {};
    foreach (m[i]) req.put(dst, m[i]);
    req.release_bus();
    n = 0;
    while (req.rx.size() < e.size() && n < 300) begin
      @(negedge mclk);
      n++;
    end
    repeat (8) @(negedge mclk);
    chk("count", req.rx.size(), e.size());
    foreach (e[i]) if (i < req.rx.size()) begin
      chk("token", req.rx[i], e[i]);
      chk("ret", req.rx_ret[i], ret);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task cw(input logic [31:0] dst, input logic [15:0] rn, input logic [31:0] v,
    input logic [23:0] ret, input logic bad);
    logic ok;
    ok = cfg_ok(dst, rn) && !bad;
    hdr(TOK_WR_CFG, ret);
    m.push_back(dt(rn[15:8]));
    m.push_back(dt(rn[7:0]));
    for (int i = 3; i >= 0; i--) m.push_back(dt(v[8*i+:8]));
    if (bad) m[m.size()-1] = ct(8'h07);
    m.push_back(ct(TOK_END));
    fin(ok);
    e.push_back(ct(TOK_END));
    if (ret[7:0] == NO_REPLY) e = {};
    run(dst, ret);
    if (ok && dst == ND) nmod[rn[2:0]] = v;
    else if (ok) tmod[rn[2:0]] = v;
  endtask
  task cr(input logic [31:0] dst, input logic [15:0] rn, input logic [23:0] ret);
    logic [31:0] w;
    w = (dst == ND) ? nmod[rn[2:0]] : tmod[rn[2:0]];
    hdr(TOK_RD_CFG, ret);
    m.push_back(dt(rn[15:8]));
    m.push_back(dt(rn[7:0]));
    m.push_back(ct(TOK_END));
    fin(cfg_ok(dst, rn));
    if (cfg_ok(dst, rn)) for (int i = 3; i >= 0; i--) e.push_back(dt(w[8*i+:8]));
    e.push_back(ct(TOK_END));
    run(dst, ret);
  endtask
  task pa(input logic we, input logic [7:0] p, input logic [7:0] rn, input logic [7:0] sz,
    input logic [23:0] ret);
    logic ok;
    logic [7:0] b;
    ok = p < 8'd4 && sz >= 8'd1 && sz <= PER_MAX_SIZE && int'(rn) + int'(sz) <= 16;
    hdr(we ? TOK_WR_PER : TOK_RD_PER, ret);
    m.push_back(dt(rn));
    m.push_back(dt(sz));
    fin(ok);
    for (int i = 0; i < int'(sz); i++) begin
      b = $random(seed);
      if (we) m.push_back(dt(b));
      if (we && ok) pmod[p][rn+i] = b;
      else if (ok) e.push_back(dt(pmod[p][rn+i]));
    end
    m.push_back(ct(TOK_END));
    e.push_back(ct(TOK_END));
    if (we && ret[7:0] == NO_REPLY) e = {};
    run({NODE_ID_DEF, p, DST_PER}, ret);
  endtask
  task ps(input logic we, input logic [7:0] n, input logic [7:0] lo, input logic [31:0] v);
    logic err;
    err = lo != PS_RES_TYPE || n >= 8'd16;
    @(negedge mclk);
    ps_req = 1'b1;
    ps_we = we;
    ps_rid = {n, lo};
    ps_wdata = v;
    @(negedge mclk);
    ps_req = 1'b0;
    chk("ps_done", ps_done, 1);
    chk("ps_err", ps_err, err);
    if (!we) chk("ps_rdata", ps_rdata, err ? 32'h0 : psm[n[3:0]]);
    else if (!err) psm[n[3:0]] = v;
    @(negedge mclk);
    chk("ps_done", ps_done, 0);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge mclk);
    fails++;
    test_done();
  end
  initial begin
    clear_models();
    repeat (3) @(negedge mclk);
    nrst = 1'b1;
    chk("busy", busy, 0);
    cr(TD, 16'h0007, 24'h000102);
    cw(TD, 16'h0003, 32'h8421c3e7, 24'h000203, 1'b0);
    cr(TD, 16'h0003, 24'h000204);
    cw(ND, 16'h0007, 32'h5a0f1e2d, 24'h000301, 1'b0);
    cr(ND, 16'h0007, 24'h000302);
    cw(TD, 16'h0008, 32'h00000001, 24'h000401, 1'b0);
    cr(ND, 16'h0100, 24'h000402);
    cw(TD, 16'h0002, 32'h13579bdf, 24'h0005ff, 1'b0);
    cw(TD, 16'h0002, 32'hffffffff, 24'h000601, 1'b1);
    cr(TD, 16'h0002, 24'h000602);
    cw({TILE_ID_DEF, 16'h1234}, 16'h0001, 32'h1, 24'h000701, 1'b0);
    hdr(8'h55, 24'h000801);
    m.push_back(ct(TOK_END));
    fin(1'b0);
    e.push_back(ct(TOK_END));
    run(TD, 24'h000801);
    pa(1'b1, 8'h01, 8'h0e, 8'h02, 24'h000901);
    pa(1'b0, 8'h01, 8'h0e, 8'h02, 24'h000902);
    pa(1'b1, 8'h02, 8'h00, 8'h04, 24'h0009ff);
    pa(1'b1, 8'h00, 8'h0f, 8'h02, 24'h000903);
    pa(1'b1, 8'h00, 8'h00, 8'h00, 24'h000904);
    pa(1'b0, 8'h03, 8'h00, 8'h05, 24'h000905);
    pa(1'b0, 8'h04, 8'h00, 8'h01, 24'h000906);
    pa(1'b1, 8'h03, 8'h05, 8'h03, 24'h000907);
    pa(1'b0, 8'h03, 8'h05, 8'h03, 24'h000908);
    pa(1'b0, 8'h03, 8'h07, 8'h01, 24'h000909);
    req.stall = 1'b1;
    fork
      begin
        repeat (40) @(negedge mclk);
        req.stall = 1'b0;
      end
    join_none
    pa(1'b0, 8'h02, 8'h00, 8'h04, 24'h000a01);
    ps(1'b1, 8'h05, PS_RES_TYPE, 32'hcafe0123);
    ps(1'b0, 8'h05, PS_RES_TYPE, 32'h0);
    ps(1'b0, 8'h05, 8'h0c, 32'h0);
    ps(1'b1, 8'h10, PS_RES_TYPE, 32'h1);
    ps(1'b0, 8'h0f, PS_RES_TYPE, 32'h0);
    // Mid-run reset must clear the tile, peripheral and status banks and leave the reply path idle
    @(negedge mclk);
    nrst = 1'b0;
    repeat (2) @(negedge mclk);
    nrst = 1'b1;
    clear_models();
    chk("out_valid", out_valid, 0);
    chk("busy", busy, 0);
    cr(TD, 16'h0003, 24'h000b01);
    pa(1'b0, 8'h01, 8'h0e, 8'h02, 24'h000b02);
    ps(1'b0, 8'h05, PS_RES_TYPE, 32'h0);
    repeat (16) begin
      r = $unsigned($random(seed)) % 10;
      rt = 24'($random(seed));
      if ($random(seed) & 1) rt[7:0] = NO_REPLY;
      if ($random(seed) & 1) cw(r[0] ? TD : ND, r[15:0], $random(seed), rt, 1'b0);
      else cr(r[1] ? TD : ND, r[15:0], rt);
    end
    test_done();
  end
endmodule // cfg_msg_access_tb
